/* fes_pkg.sv */
// fes_pkg: constants, register map and carrier types of the fabric error
// status block.
// assumes a 32-bit AHB-Lite register bus and sixteen fabric ports.
package fes_pkg;

    localparam int          PORT_COUNT  = 16;
    localparam int          ADDR_W      = 20;
    localparam int          PERIOD_W    = 16;
    localparam int          ACK_SHIFT   = 15;
    localparam int          COUNT_W     = PERIOD_W + ACK_SHIFT;

    // register byte addresses
    localparam logic [19:0] OFF_CTRL    = 20'h1_aa10;
    localparam logic [19:0] OFF_ACK     = 20'h1_aa04;
    localparam logic [19:0] OFF_LAT     = 20'h1_aa08;
    localparam logic [19:0] OFF_OVR     = 20'h1_aa0c;

    // port p sits at data bit p; bits 31..16 are reserved
    localparam int          PORT_LSB    = 0;

    // control register fields
    localparam int          PERIOD_LSB  = 0;
    localparam int          TMR_EN_BIT  = 16;
    localparam int          INT_EN_BIT  = 17;
    localparam int          DEAD_EN_BIT = 18;

    localparam logic [15:0] PERIOD_RST  = 16'h0200;
    localparam logic        TMR_EN_RST  = 1'b1;
    localparam logic        INT_EN_RST  = 1'b0;
    localparam logic        DEAD_EN_RST = 1'b0;
    localparam logic [15:0] STATUS_RST  = 16'h0000;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

    localparam logic [1:0]  HTRANS_NSEQ = 2'b10;
    localparam logic        HRESP_OKAY  = 1'b0;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WAIT = 3'b010,
        BUS_DONE = 3'b100
    } fes_bus_state_type;

    typedef struct packed {
        logic              wr_en;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } fes_bus_req_type;

endpackage

/* fes_ack_timer.sv */
// fes_ack_timer: acknowledge wait timer for one fabric port.
// assumes pending stays high while a request waits for its acknowledge.
`timescale 1ns/10ps
module fes_ack_timer #(
    parameter int SHIFT = fes_pkg::ACK_SHIFT
) (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          pending,
    input  wire logic                          enable,
    input  wire logic [fes_pkg::PERIOD_W-1:0]  period,
    output logic                               timeout
);
    import fes_pkg::*;

    logic [COUNT_W-1:0] count;
    logic               fired;
    wire  [COUNT_W-1:0] limit   = COUNT_W'({15'h0000, period} << SHIFT);
    wire                running = pending && enable && (period != '0);
    wire                hit     = running && !fired
                                  && (count + 1'b1 == limit);

    // one pulse per waiting request; a zero period stops the timer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count   <= '0;
            fired   <= 1'b0;
            timeout <= 1'b0;
        end else begin
            timeout <= hit;
            if (!running) begin
                count <= '0;
                fired <= 1'b0;
            end else if (!fired) begin
                count <= count + 1'b1;
                fired <= hit;
            end
        end
    end

endmodule

/* fes_ahb_slave.sv */
// fes_ahb_slave: AHB-Lite front end, one wait state on every transfer.
// assumes single word transfers; the response is always OKAY.
`timescale 1ns/10ps
module fes_ahb_slave (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    input  wire logic [31:0]             rd_value,
    output fes_pkg::fes_bus_req_type     req,
    output logic                         hreadyout,
    output logic [31:0]                  hrdata,
    output logic                         hresp
);
    import fes_pkg::*;

    fes_bus_state_type         state;
    logic [ADDR_W-1:0]         addr;
    logic                      is_write;
    wire                       take = hsel && hready && htrans[1];
    wire                       in_wait = (state == BUS_WAIT);

    assign req.wr_en = in_wait && is_write;
    assign req.addr  = addr;
    assign req.wdata = hwdata;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state     <= BUS_IDLE;
            addr      <= '0;
            is_write  <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= WORD_ZERO;
            hresp     <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
            case (state)
                BUS_WAIT: begin
                    hrdata    <= is_write ? WORD_ZERO : rd_value;
                    hreadyout <= 1'b1;
                    state     <= BUS_DONE;
                end
                BUS_IDLE, BUS_DONE: begin
                    if (take) begin
                        addr      <= haddr[ADDR_W-1:0];
                        is_write  <= hwrite;
                        hreadyout <= 1'b0;
                        state     <= BUS_WAIT;
                    end else begin
                        state <= BUS_IDLE;
                    end
                end
                default: begin
                    state     <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

endmodule

/* fes_status_irq.sv */
// fes_status_irq: per-port error-acknowledge and multicast latency status
// with fabric interrupt, summary flags and broadcast buffer controls.
// assumes port events are single-cycle pulses synchronous to clk.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps

module fes_status_irq #(
    parameter int ACK_SHIFT = fes_pkg::ACK_SHIFT
) (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic                                 hreadyout,
    output logic [31:0]                          hrdata,
    output logic                                 hresp,
    input  wire logic [fes_pkg::PORT_COUNT-1:0]  ack_pending,
    input  wire logic [fes_pkg::PORT_COUNT-1:0]  latency_expired,
    output logic                                 fabric_irq,
    output logic                                 error_ack_summary,
    output logic                                 multicast_latency_summary,
    output logic [fes_pkg::PORT_COUNT-1:0]       multicast_block,
    output logic [fes_pkg::PORT_COUNT-1:0]       broadcast_purge
);
    import fes_pkg::*;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
        reg_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    fes_bus_req_type          req;
    logic [31:0]              rd_value;

    logic [PERIOD_W-1:0]      error_ack_timeout_period;
    logic                     error_ack_timer_enable;
    logic                     error_ack_interrupt_enable;
    logic                     auto_dead_port_enable;
    logic [PORT_COUNT-1:0]    fabric_error_ack_status;
    logic [PORT_COUNT-1:0]    multicast_latency_error;
    logic [PORT_COUNT-1:0]    timeout_event;

    // hsize is fixed at a word on this bus; it is not decoded
    fes_ahb_slave u_bus (
        .clk       (clk),
        .rstn      (rstn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .rd_value  (rd_value),
        .req       (req),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp)
    );

    // one wait timer per port
    genvar p;
    generate
        for (p = 0; p < PORT_COUNT; p++) begin : g_timer
            fes_ack_timer #(.SHIFT(ACK_SHIFT)) u_timer (
                .clk     (clk),
                .rstn    (rstn),
                .pending (ack_pending[p]),
                .enable  (error_ack_timer_enable),
                .period  (error_ack_timeout_period),
                .timeout (timeout_event[p])
            );
        end
    endgenerate

    // register decode
    wire                  wr_ctrl = req.wr_en && reg_hit(req.addr, OFF_CTRL);
    wire                  wr_ack  = req.wr_en && reg_hit(req.addr, OFF_ACK);
    wire                  wr_lat  = req.wr_en && reg_hit(req.addr, OFF_LAT);
    wire                  wr_ovr  = req.wr_en && reg_hit(req.addr, OFF_OVR);
    wire [PORT_COUNT-1:0] wr_bits = req.wdata[PORT_LSB +: PORT_COUNT];

    wire [PORT_COUNT-1:0] ack_clear = wr_ack ? wr_bits : '0;
    wire [PORT_COUNT-1:0] lat_clear = wr_lat ? wr_bits : '0;
    wire [PORT_COUNT-1:0] ovr_set   = wr_ovr ? wr_bits : '0;

    // set terms come after the clear so an event is never lost
    wire [PORT_COUNT-1:0] next_ack_status =
        (fabric_error_ack_status & ~ack_clear) | timeout_event;
    wire [PORT_COUNT-1:0] next_latency_error =
        (multicast_latency_error & ~lat_clear)
        | latency_expired | ovr_set;

    wire [31:0] ctrl_word = {13'h0000,
                             auto_dead_port_enable,
                             error_ack_interrupt_enable,
                             error_ack_timer_enable,
                             error_ack_timeout_period};

    // unmapped addresses read zero; reserved upper half reads zero
    assign rd_value =
        reg_hit(req.addr, OFF_CTRL) ? ctrl_word :
        reg_hit(req.addr, OFF_ACK)  ? {16'h0000, fabric_error_ack_status} :
        reg_hit(req.addr, OFF_LAT)  ? {16'h0000, multicast_latency_error} :
        WORD_ZERO;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            error_ack_timeout_period   <= PERIOD_RST;
            error_ack_timer_enable     <= TMR_EN_RST;
            error_ack_interrupt_enable <= INT_EN_RST;
            auto_dead_port_enable      <= DEAD_EN_RST;
        end else if (wr_ctrl) begin
            error_ack_timeout_period   <= req.wdata[PERIOD_LSB +: PERIOD_W];
            error_ack_timer_enable     <= req.wdata[TMR_EN_BIT];
            error_ack_interrupt_enable <= req.wdata[INT_EN_BIT];
            auto_dead_port_enable      <= req.wdata[DEAD_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fabric_error_ack_status <= STATUS_RST;
            multicast_latency_error <= STATUS_RST;
        end else begin
            fabric_error_ack_status <= next_ack_status;
            multicast_latency_error <= next_latency_error;
        end
    end

    // outputs other than broadcast_purge follow the next state so they move with the status bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fabric_irq                <= 1'b0;
            error_ack_summary         <= 1'b0;
            multicast_latency_summary <= 1'b0;
            multicast_block           <= '0;
            broadcast_purge           <= '0;
        end else begin
            fabric_irq        <= error_ack_interrupt_enable
                                 && (|next_ack_status);
            error_ack_summary <= |next_ack_status;
            multicast_latency_summary <= |next_latency_error;
            multicast_block   <= next_latency_error
                                 & {PORT_COUNT{auto_dead_port_enable}};
            // the buffer keeps a packet already on the wire
            broadcast_purge   <= ovr_set;
        end
    end

    sequence s_clear_all;
        wr_ack && (&wr_bits) && (timeout_event == '0);
    endsequence

    sequence s_override;
        wr_ovr && (wr_bits != '0);
    endsequence

    // status reads only; the control word uses the upper half
    reserved_zero_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (!hreadyout && !req.wr_en
         && (reg_hit(req.addr, OFF_ACK) || reg_hit(req.addr, OFF_LAT)))
        |=> (hrdata[31:16] == 16'h0000))
        else $error("reserved bits of a read are not zero");

    timeout_sets_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (timeout_event != '0) |=>
            ((fabric_error_ack_status & $past(timeout_event))
             == $past(timeout_event)))
        else $error("ack timeout did not set its status bit");

    w1c_clears_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (wr_ack && ((wr_bits & timeout_event) == '0)) |=>
            ((fabric_error_ack_status & $past(wr_bits)) == '0)
            && ((fabric_error_ack_status & ~$past(wr_bits))
                == (($past(fabric_error_ack_status)
                     | $past(timeout_event)) & ~$past(wr_bits))))
        else $error("write one did not clear only its status bits");

    irq_or_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ##1 fabric_irq == ($past(error_ack_interrupt_enable)
                           && (|fabric_error_ack_status)))
        else $error("interrupt request differs from gated status OR");

    ack_summary_a: assert property (
        @(posedge clk) disable iff (!rstn)
        error_ack_summary == (|fabric_error_ack_status))
        else $error("error-ack summary differs from status OR");

    clear_drops_irq_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_clear_all |=> (!fabric_irq && !error_ack_summary))
        else $error("interrupt stays up after every bit was cleared");

    lat_sets_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (latency_expired != '0) |=>
            ((multicast_latency_error & $past(latency_expired))
             == $past(latency_expired)))
        else $error("latency expiry did not set its error bit");

    dead_block_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ##1 multicast_block == (multicast_latency_error
                                & {PORT_COUNT{$past(auto_dead_port_enable)}}))
        else $error("multicast block does not follow flagged ports");

    lat_summary_a: assert property (
        @(posedge clk) disable iff (!rstn)
        multicast_latency_summary == (|multicast_latency_error))
        else $error("latency summary differs from error bits");

    lat_w1c_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (wr_lat && !wr_ovr && ((wr_bits & latency_expired) == '0)) |=>
            ((multicast_latency_error & $past(wr_bits)) == '0))
        else $error("latency error bit not cleared by write one");

    timeout_cause_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (timeout_event != '0) |->
            (($past(ack_pending) & timeout_event) == timeout_event)
            && $past(error_ack_timer_enable)
            && ($past(error_ack_timeout_period) != '0))
        else $error("ack timeout without a waiting request or period");

    irq_enable_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !error_ack_interrupt_enable |=> !fabric_irq)
        else $error("interrupt raised while its enable is clear");

    override_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_override |=> (broadcast_purge == $past(wr_bits))
            && ((multicast_latency_error & $past(wr_bits))
                == $past(wr_bits)) ##1 (broadcast_purge == '0)
                || $past(wr_ovr))
        else $error("override did not set the bit and pulse the purge");

    set_wins_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ((ack_clear & timeout_event) != '0) |=>
            ((fabric_error_ack_status & $past(timeout_event))
             == $past(timeout_event)))
        else $error("a clear in the same cycle swallowed an ack event");

endmodule

/* fes_port_model.sv */
// fes_port_model: port and fabric side that reports per-port events.
// assumes the bench requests events just after a rising clock edge.
`timescale 1ns/10ps
module fes_port_model (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic [fes_pkg::PORT_COUNT-1:0]  pend_req,
    input  wire logic [fes_pkg::PORT_COUNT-1:0]  lat_req,
    input  wire logic [fes_pkg::PORT_COUNT-1:0]  lat_hold,
    output logic      [fes_pkg::PORT_COUNT-1:0]  ack_pending,
    output logic      [fes_pkg::PORT_COUNT-1:0]  latency_expired
);
    import fes_pkg::*;
    logic [PORT_COUNT-1:0] lat_last;
    wire  [PORT_COUNT-1:0] lat_edge = lat_req & ~lat_last;

    // a request stays pending until the bench withdraws it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_pending     <= 16'h0000;
            latency_expired <= 16'h0000;
            lat_last        <= 16'h0000;
        end else begin
            ack_pending     <= pend_req;
            latency_expired <= lat_edge | lat_hold;
            lat_last        <= lat_req;
        end
    end
endmodule

/* tb_top.sv */
// tb_top: self-checking bench for the fabric error status block.
// assumes one AHB-Lite slave, so hready is the slave's own hreadyout.
`timescale 1ns/10ps
module tb_top;
    import fes_pkg::*;
    logic        clk, rstn, hsel, hwrite, rd_dphase;
    logic [31:0] haddr, hwdata, hrdata, exp_w;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, fabric_irq, error_ack_summary;
    logic        multicast_latency_summary;
    logic [15:0] ack_pending, latency_expired, multicast_block;
    logic [15:0] broadcast_purge, pend_req, lat_req, lat_hold, v, m;
    logic [15:0] purge_cap;
    logic [3:0]  p;
    logic [31:0] exp_q[$];
    integer      seed, miscompares, samples_checked;

    fes_status_irq #(.ACK_SHIFT(2)) fes_status_irq_inst (
        .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .ack_pending(ack_pending),
        .latency_expired(latency_expired), .fabric_irq(fabric_irq),
        .error_ack_summary(error_ack_summary),
        .multicast_latency_summary(multicast_latency_summary),
        .multicast_block(multicast_block),
        .broadcast_purge(broadcast_purge));

    fes_port_model fes_port_model_inst (
        .clk(clk), .rstn(rstn), .pend_req(pend_req), .lat_req(lat_req),
        .lat_hold(lat_hold), .ack_pending(ack_pending),
        .latency_expired(latency_expired));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cmp_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_vec(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // single word transfer; reads leave their expectation in the queue
    task automatic bus(input logic wr, input logic [19:0] addr,
                       input logic [31:0] wdata, input logic [31:0] exp);
        int n;
        n = 0;
        if (!wr)
            exp_q.push_back(exp);
        haddr  <= {12'h000, addr};
        htrans <= HTRANS_NSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (!hreadyout && n < 50) begin
            @(posedge clk);
            n++;
        end
        htrans <= 2'b00;
        hwdata <= wdata;
        @(posedge clk);
        while (!hreadyout && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
            miscompares++;
    endtask

    // outputs looked at mid-cycle, where they are settled
    task automatic chk_out(input logic irq, input logic eas,
                           input logic mls, input logic [15:0] blk);
        @(negedge clk);
        cmp_vec("fabric_irq", {15'h0000, irq}, {15'h0000, fabric_irq});
        cmp_vec("ack_summary", {15'h0000, eas},
                {15'h0000, error_ack_summary});
        cmp_vec("lat_summary", {15'h0000, mls},
                {15'h0000, multicast_latency_summary});
        cmp_vec("multicast_block", blk, multicast_block);
        @(posedge clk);
    endtask

    task automatic end_test(input string name);
        $display("test %0s finished", name);
    endtask

    // read results are taken as they complete and matched to the oldest note
    always @(posedge clk) begin
        if (rd_dphase && hreadyout) begin
            rd_dphase <= 1'b0;
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_beef;
            cmp_word("hrdata", exp_w, hrdata);
            cmp_word("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
        end
        if (hsel && hreadyout && htrans[1] && !hwrite && rstn)
            rd_dphase <= 1'b1;
    end

    // purge pulses last one cycle; caught mid-cycle, where they are settled
    always @(negedge clk)
        if (broadcast_purge != 16'h0000)
            purge_cap = broadcast_purge;

    initial begin
        #100000;
        miscompares++;
        conclude();
    end

    initial begin
        seed = 32'h6cbc;
        miscompares = 0;
        samples_checked = 0;
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        rd_dphase = 1'b0;
        pend_req = 16'h0000;
        lat_req = 16'h0000;
        lat_hold = 16'h0000;
        purge_cap = 16'h0000;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        hsel <= 1'b1;
        @(posedge clk);
        bus(1'b0, OFF_ACK, 32'h0, 32'h0000_0000);
        bus(1'b0, OFF_LAT, 32'h0, 32'h0000_0000);
        bus(1'b0, OFF_OVR, 32'h0, 32'h0000_0000);
        bus(1'b0, OFF_CTRL, 32'h0, 32'h0001_0200);
        bus(1'b0, 20'h1_aa14, 32'h0, 32'h0000_0000);
        chk_out(1'b0, 1'b0, 1'b0, 16'h0000);
        end_test("reset");

        bus(1'b1, OFF_CTRL, 32'h0003_0003, 32'h0);
        repeat (3) begin
            p = 4'($random(seed));
            pend_req <= (16'h0001 << p) | (16'h0100 << p[2:0]);
            repeat (8) @(posedge clk);
            chk_out(1'b0, 1'b0, 1'b0, 16'h0000);
            repeat (12) @(posedge clk);
            pend_req <= 16'h0000;
            chk_out(1'b1, 1'b1, 1'b0, 16'h0000);
            v = (16'h0001 << p) | (16'h0100 << p[2:0]);
            bus(1'b0, OFF_ACK, 32'h0, {16'h0000, v});
            bus(1'b1, OFF_ACK, 32'hffff_0000, 32'h0);
            bus(1'b0, OFF_ACK, 32'h0, {16'h0000, v});
            bus(1'b1, OFF_ACK, {16'h0000, 16'h0001 << p}, 32'h0);
            bus(1'b0, OFF_ACK, 32'h0, {16'h0000, v & ~(16'h0001 << p)});
            chk_out(v != (16'h0001 << p), v != (16'h0001 << p), 1'b0,
                    16'h0000);
            bus(1'b1, OFF_ACK, 32'hffff_ffff, 32'h0);
            chk_out(1'b0, 1'b0, 1'b0, 16'h0000);
        end
        end_test("ack_timeout");

        p = 4'($random(seed));
        bus(1'b1, OFF_CTRL, 32'h0001_0003, 32'h0);
        pend_req <= 16'h0001 << p;
        repeat (20) @(posedge clk);
        chk_out(1'b0, 1'b1, 1'b0, 16'h0000);
        pend_req <= 16'h0000;
        bus(1'b1, OFF_ACK, 32'hffff_ffff, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h0001_0000, 32'h0);
        pend_req <= 16'h0001 << p;
        repeat (30) @(posedge clk);
        bus(1'b0, OFF_ACK, 32'h0, 32'h0000_0000);
        pend_req <= 16'h0000;
        end_test("ack_gating");

        v = 16'($random(seed)) | 16'h8001;
        lat_req <= v;
        @(posedge clk);
        lat_req <= 16'h0000;
        repeat (3) @(posedge clk);
        bus(1'b0, OFF_LAT, 32'h0, {16'h0000, v});
        chk_out(1'b0, 1'b0, 1'b1, 16'h0000);
        bus(1'b1, OFF_CTRL, 32'h0005_0003, 32'h0);
        chk_out(1'b0, 1'b0, 1'b1, v);
        m = 16'($random(seed));
        bus(1'b1, OFF_LAT, {16'hffff, m}, 32'h0);
        bus(1'b0, OFF_LAT, 32'h0, {16'h0000, v & ~m});
        bus(1'b1, OFF_LAT, 32'h0000_ffff, 32'h0);
        chk_out(1'b0, 1'b0, 1'b0, 16'h0000);
        end_test("latency");

        m = 16'($random(seed)) | 16'h0010;
        bus(1'b1, OFF_OVR, {16'h0000, m}, 32'h0);
        cmp_vec("purge", m, purge_cap);
        @(negedge clk);
        cmp_vec("purge_end", 16'h0000, broadcast_purge);
        @(posedge clk);
        bus(1'b0, OFF_LAT, 32'h0, {16'h0000, m});
        chk_out(1'b0, 1'b0, 1'b1, m);
        bus(1'b1, OFF_LAT, 32'h0000_ffff, 32'h0);
        end_test("override");

        p = 4'($random(seed));
        lat_hold <= 16'h0001 << p;
        repeat (2) @(posedge clk);
        bus(1'b1, OFF_LAT, {16'h0000, 16'h0001 << p}, 32'h0);
        bus(1'b0, OFF_LAT, 32'h0, {16'h0000, 16'h0001 << p});
        lat_hold <= 16'h0000;
        repeat (2) @(posedge clk);
        bus(1'b1, OFF_LAT, {16'h0000, 16'h0001 << p}, 32'h0);
        bus(1'b0, OFF_LAT, 32'h0, 32'h0000_0000);
        pend_req <= 16'h0001 << p;
        repeat (12) @(posedge clk);
        // the clear lands in the very cycle of the timeout pulse
        bus(1'b1, OFF_ACK, {16'h0000, 16'h0001 << p}, 32'h0);
        pend_req <= 16'h0000;
        bus(1'b0, OFF_ACK, 32'h0, {16'h0000, 16'h0001 << p});
        bus(1'b1, OFF_ACK, 32'h0000_ffff, 32'h0);
        chk_out(1'b0, 1'b0, 1'b0, 16'h0000);
        end_test("set_priority");
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule
